// >>> core/prom_prog_defines.vh
// Timing and geometry constants for the fuse memory programmer
`ifndef PROM_PROG_DEFINES_VH
`define PROM_PROG_DEFINES_VH
`define CLK_MHZ            25
`define ADDR_W             12
`define DATA_W             4
`define RAMP_US            2
`define RAMP_CYC           (`RAMP_US * `CLK_MHZ)
`define SETTLE_US          20
`define SETTLE_CYC         (`SETTLE_US * `CLK_MHZ)
`define PULSE_US           200
`define PULSE_CYC          (`PULSE_US * `CLK_MHZ)
`define TOTAL_US           1000
`define VERIFY_CYC         4
`define PULSE_MAX          (`TOTAL_US / `PULSE_US)
`endif

// >>> core/prom_prog.v
// Programmer that blows fuses of a 4096 x 4 fuse memory word by word
`timescale 1ns/1ps
`default_nettype none
`include "prom_prog_defines.vh"
module prom_prog (
  input  wire        CORE_CLK_I,
  input  wire        RSTN_I,
  input  wire        START_I,
  input  wire [11:0] WORD_ADDR_I,
  input  wire [3:0]  WORD_ZEROS_I,
  input  wire [3:0]  PROM_DATA_I,
  output reg  [11:0] PROM_ADDR_O,
  output reg  [1:0]  CHIP_SELECT_INPUTS_O,
  output reg  [3:0]  PROM_DATA_O,
  output reg  [3:0]  PROM_DATA_OEN_O,
  output reg         SUPPLY_HIGH_O,
  output reg         SUPPLY_RAMP_O,
  output reg         BUSY_O,
  output reg         DONE_O,
  output reg  [3:0]  REJECT_O
);
  // ==========================================================
  // State encoding
  localparam [7:0] S_IDLE   = 8'h01;
  localparam [7:0] S_RAMPUP = 8'h02;
  localparam [7:0] S_SETTLE = 8'h04;
  localparam [7:0] S_PULSE  = 8'h08;
  localparam [7:0] S_TAIL   = 8'h10;
  localparam [7:0] S_RAMPDN = 8'h20;
  localparam [7:0] S_VERIFY = 8'h40;
  localparam [7:0] S_CHECK  = 8'h80;

  reg [7:0]  state_q;
  reg [15:0] cnt_q;
  reg [1:0]  bit_q;
  reg [3:0]  todo_q;
  reg [3:0]  want_q;
  reg [2:0]  tot0_q;
  reg [2:0]  tot1_q;
  reg [2:0]  tot2_q;
  reg [2:0]  tot3_q;
  reg [3:0]  sample_q;

  // Finds the lowest bit still to pulse at or above a position
  function [2:0] next_bit;
    input [3:0] mask;
    input [1:0] from;
    integer k;
    begin
      next_bit = 3'h4;
      for (k = 3; k >= 0; k = k - 1)
        if (mask[k] && (k >= from))
          next_bit = k[2:0];
    end
  endfunction

  wire [3:0] spent = {tot3_q == `PULSE_MAX, tot2_q == `PULSE_MAX,
                      tot1_q == `PULSE_MAX, tot0_q == `PULSE_MAX};
  wire [3:0] fail  = want_q & sample_q;
  wire [2:0] nb    = next_bit(todo_q & ~(4'h1 << bit_q), bit_q);
  wire [2:0] first = next_bit(todo_q, 2'h0);

  // ==========================================================
  // Sequencer
  always @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_q              <= S_IDLE;
      cnt_q                <= 16'h0000;
      bit_q                <= 2'h0;
      todo_q               <= 4'h0;
      want_q               <= 4'h0;
      tot0_q               <= 3'h0;
      tot1_q               <= 3'h0;
      tot2_q               <= 3'h0;
      tot3_q               <= 3'h0;
      sample_q             <= 4'hf;
      PROM_ADDR_O          <= 12'h000;
      CHIP_SELECT_INPUTS_O <= 2'h3;
      PROM_DATA_O          <= 4'h0;
      PROM_DATA_OEN_O      <= 4'hf;
      SUPPLY_HIGH_O        <= 1'b0;
      SUPPLY_RAMP_O        <= 1'b0;
      BUSY_O               <= 1'b0;
      DONE_O               <= 1'b0;
      REJECT_O             <= 4'h0;
    end
    else
    begin
      DONE_O <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (START_I)
          begin
            PROM_ADDR_O          <= WORD_ADDR_I;
            want_q               <= WORD_ZEROS_I;
            todo_q               <= WORD_ZEROS_I;
            tot0_q               <= 3'h0;
            tot1_q               <= 3'h0;
            tot2_q               <= 3'h0;
            tot3_q               <= 3'h0;
            REJECT_O             <= 4'h0;
            BUSY_O               <= 1'b1;
            CHIP_SELECT_INPUTS_O <= 2'h3;
            PROM_DATA_OEN_O      <= 4'hf;
            SUPPLY_HIGH_O        <= 1'b1;
            SUPPLY_RAMP_O        <= 1'b1;
            cnt_q                <= 16'h0000;
            state_q              <= S_RAMPUP;
          end
        end
        S_RAMPUP:
        begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `RAMP_CYC - 1)
          begin
            SUPPLY_RAMP_O <= 1'b0;
            cnt_q         <= 16'h0000;
            bit_q         <= first[1:0];
            // An empty word skips straight to the tail with no pulse
            state_q       <= (first == 3'h4) ? S_TAIL : S_SETTLE;
          end
        end
        S_SETTLE:
        begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `SETTLE_CYC - 1)
          begin
            cnt_q               <= 16'h0000;
            PROM_DATA_O[bit_q]     <= 1'b1;
            PROM_DATA_OEN_O[bit_q] <= 1'b0;
            state_q             <= S_PULSE;
          end
        end
        S_PULSE:
        begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `PULSE_CYC - 1)
          begin
            cnt_q           <= 16'h0000;
            PROM_DATA_O     <= 4'h0;
            PROM_DATA_OEN_O <= 4'hf;
            case (bit_q)
              2'h0: tot0_q <= tot0_q + 3'h1;
              2'h1: tot1_q <= tot1_q + 3'h1;
              2'h2: tot2_q <= tot2_q + 3'h1;
              default: tot3_q <= tot3_q + 3'h1;
            endcase
            todo_q[bit_q] <= 1'b0;
            if (nb != 3'h4)
            begin
              bit_q   <= nb[1:0];
              state_q <= S_SETTLE;
            end
            else
              state_q <= S_TAIL;
          end
        end
        S_TAIL:
        begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `SETTLE_CYC - 1)
          begin
            cnt_q         <= 16'h0000;
            SUPPLY_HIGH_O <= 1'b0;
            SUPPLY_RAMP_O <= 1'b1;
            state_q       <= S_RAMPDN;
          end
        end
        S_RAMPDN:
        begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `RAMP_CYC - 1)
          begin
            cnt_q                <= 16'h0000;
            SUPPLY_RAMP_O        <= 1'b0;
            CHIP_SELECT_INPUTS_O <= 2'h0;
            state_q              <= S_VERIFY;
          end
        end
        S_VERIFY:
        begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `VERIFY_CYC - 1)
          begin
            sample_q <= PROM_DATA_I;
            state_q  <= S_CHECK;
          end
        end
        S_CHECK:
        begin
          CHIP_SELECT_INPUTS_O <= 2'h3;
          cnt_q                <= 16'h0000;
          if ((fail & ~spent) != 4'h0)
          begin
            todo_q        <= fail & ~spent;
            SUPPLY_HIGH_O <= 1'b1;
            SUPPLY_RAMP_O <= 1'b1;
            state_q       <= S_RAMPUP;
          end
          else
          begin
            REJECT_O <= fail;
            BUSY_O   <= 1'b0;
            DONE_O   <= 1'b1;
            state_q  <= S_IDLE;
          end
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end
endmodule // prom_prog
`default_nettype wire

// >>> dv/prom_prog_chk.sv
// Port assertions for the fuse programmer
`timescale 1ns/1ps
`default_nettype none
module prom_prog_chk (
  input wire logic        CORE_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        START_I,
  input wire logic [11:0] WORD_ADDR_I,
  input wire logic [11:0] PROM_ADDR_O,
  input wire logic [1:0]  CHIP_SELECT_INPUTS_O,
  input wire logic [3:0]  PROM_DATA_O,
  input wire logic [3:0]  PROM_DATA_OEN_O,
  input wire logic        SUPPLY_HIGH_O,
  input wire logic        SUPPLY_RAMP_O,
  input wire logic        BUSY_O
);
  // ==========
  // Ramp, pulse and quiet-gap counters
  wire  [3:0]  act = ~PROM_DATA_OEN_O & PROM_DATA_O;
  logic [5:0]  rmp_q;
  logic [12:0] pls_q;
  logic [12:0] gap_q;
  logic        hit_q;
  always @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rmp_q <= 6'h0;
      pls_q <= 13'h0;
      gap_q <= 13'h0;
      hit_q <= 1'b0;
    end
    else
    begin
      rmp_q <= SUPPLY_RAMP_O ? rmp_q + 6'h1 : 6'h0;
      pls_q <= (|act) ? pls_q + 13'h1 : 13'h0;
      gap_q <= ((|act) || SUPPLY_RAMP_O) ? 13'h0 : gap_q + {12'h0, gap_q != 13'h1fff};
      hit_q <= SUPPLY_HIGH_O && (hit_q || (|act));
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_take; START_I && !BUSY_O; endsequence
  sequence s_up; BUSY_O && SUPPLY_HIGH_O && SUPPLY_RAMP_O; endsequence
  AST_START: assert property (s_take |=> s_up ##0 (PROM_ADDR_O == $past(WORD_ADDR_I)))
    else $error("start not taken with address");
  AST_ADDR_HOLD: assert property (BUSY_O && $past(BUSY_O) |-> $stable(PROM_ADDR_O))
    else $error("address moved while busy");
  AST_CS_PGM: assert property (SUPPLY_HIGH_O || SUPPLY_RAMP_O |-> CHIP_SELECT_INPUTS_O == 2'b11)
    else $error("chip selected while supply raised");
  AST_NO_EARLY: assert property ((|act) |-> SUPPLY_HIGH_O && !SUPPLY_RAMP_O)
    else $error("pulse outside programming level");
  AST_RAMP: assert property ($fell(SUPPLY_RAMP_O) |-> rmp_q == 6'd50)
    else $error("ramp length wrong");
  AST_PULSE: assert property ($fell(|act) |-> pls_q == 13'd5000)
    else $error("pulse length wrong");
  AST_SETTLE: assert property ($rose(|act) |-> gap_q >= 13'd250 && gap_q <= 13'd2500)
    else $error("settle before pulse out of range");
  AST_TAIL: assert property ($fell(SUPPLY_HIGH_O) && hit_q |-> gap_q >= 13'd250)
    else $error("supply lowered too soon");
  AST_VERIFY: assert property (CHIP_SELECT_INPUTS_O == 2'b00 |-> !SUPPLY_HIGH_O && !SUPPLY_RAMP_O && PROM_DATA_OEN_O == 4'hf)
    else $error("verify read not at normal supply");
  AST_ONEHOT: assert property ($onehot0(~PROM_DATA_OEN_O))
    else $error("two outputs pulsed at once");
endmodule // prom_prog_chk
bind prom_prog prom_prog_chk u_chk (.*);
`default_nettype wire

// >>> dv/fuse_mem_model.sv
// Behavioural 4096 x 4 fuse memory
`timescale 1ns/1ps
`default_nettype none
module fuse_mem_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [1:0]  cs_i,
  input  wire logic [3:0]  pgm_i,
  input  wire logic [3:0]  pgm_oen_i,
  input  wire logic        sup_i,
  input  wire logic [3:0]  need_i,
  output logic      [3:0]  data_o
);
  wire  [3:0]  act = ~pgm_oen_i & pgm_i & {4{sup_i}};
  logic [3:0]  mem [0:4095];
  logic [3:0]  cnt [0:3];
  logic [3:0]  act_q = 4'h0;
  logic [3:0]  last_q = 4'h0;
  logic [11:0] a_q = 12'h0;
  initial
  begin
    for (int i = 0; i < 4096; i++) mem[i] = 4'hf;
    for (int i = 0; i < 4; i++) cnt[i] = 4'h0;
  end
  // A fuse blows only after need_i rising pulse edges on the same word
  always @(posedge clk_i)
  begin
    act_q <= act;
    a_q <= addr_i;
    if (cs_i == 2'b00) last_q <= mem[addr_i];
    for (int b = 0; b < 4; b++)
      if (a_q != addr_i) cnt[b] <= 4'h0;
      else if (act[b] && !act_q[b])
      begin
        cnt[b] <= cnt[b] + 4'h1;
        if (cnt[b] + 4'h1 >= need_i) mem[addr_i][b] <= 1'b0;
      end
  end
  // Deselected outputs float: show the inverse of the last word driven
  assign data_o = (cs_i == 2'b00) ? mem[addr_i] : ~last_q;
endmodule // fuse_mem_model
`default_nettype wire

// >>> dv/prom_prog_tb.sv
// Self-checking bench for the fuse programmer
`timescale 1ns/1ps
`default_nettype none
module prom_prog_tb;
  logic        clk = 0, rst_n = 0, start = 0, sup, ramp, busy, done;
  logic [11:0] waddr = 12'h0, paddr;
  logic [3:0]  zeros = 4'h0, need = 4'h1, rd, pd, poen, rej;
  logic [1:0]  cs;
  logic [23:0] rows [3] = '{{12'h000, 4'h0, 4'h1, 4'h0}, {12'hfff, 4'h5, 4'h1, 4'h0},
                            {12'h456, 4'h2, 4'h6, 4'h2}};
  int          fails = 0, tests_run = 0, n;
  always #20 clk = ~clk;
  prom_prog DUT (.CORE_CLK_I(clk), .RSTN_I(rst_n), .START_I(start), .WORD_ADDR_I(waddr),
    .WORD_ZEROS_I(zeros), .PROM_DATA_I(rd), .PROM_ADDR_O(paddr), .CHIP_SELECT_INPUTS_O(cs),
    .PROM_DATA_O(pd), .PROM_DATA_OEN_O(poen), .SUPPLY_HIGH_O(sup), .SUPPLY_RAMP_O(ramp),
    .BUSY_O(busy), .DONE_O(done), .REJECT_O(rej));
  fuse_mem_model u_mem (.clk_i(clk), .addr_i(paddr), .cs_i(cs), .pgm_i(pd), .pgm_oen_i(poen),
    .sup_i(sup), .need_i(need), .data_o(rd));
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task run(input logic [11:0] a, input logic [3:0] z, input logic [3:0] r);
    waddr = a;
    zeros = z;
    start = 1;
    @(negedge clk);
    start = 0;
    for (n = 0; done !== 1'b1 && n < 40000; n++) @(negedge clk);
    check("done", done, 1);
    check("reject", rej, r);
    check("word", u_mem.mem[a], 4'(~(z & ~r)));
  endtask
  initial
  begin
    #(40 * 95000);
    fails++;
    end_of_test;
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    foreach (rows[i])
    begin
      need = rows[i][7:4];
      run(rows[i][23:12], rows[i][11:8], rows[i][3:0]);
    end
    need = 4'h5;
    run(12'h789, 4'h2, 4'h0);
    need = 4'h2;
    run(12'h123, 4'h2, 4'h0);
    waddr = 12'h321;
    zeros = 4'h1;
    start = 1;
    @(negedge clk);
    start = 0;
    repeat (600) @(negedge clk);
    check("pulse", poen, 4'he);
    rst_n = 0;
    @(negedge clk);
    check("reset", {cs, poen, sup, ramp, busy, done}, 10'h3f0);
    check("reset data", {paddr, pd}, 16'h0000);
    check("reset reject", rej, 4'h0);
    rst_n = 1;
    run(12'h321, 4'h0, 4'h0);
    end_of_test;
  end
endmodule // prom_prog_tb
`default_nettype wire
